//--- burst_counter.sv
// two-bit wraparound burst counter
// assumes load and step come from the port logic on the same clock
`timescale 1ns/10ps
`include "sram_port_regs.svh"
module burst_counter
    import sram_port_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic load,
    input wire burst_low_type seed,
    input wire logic step,
    input wire logic mode,
    output burst_low_type cur_low,
    output burst_low_type next_low
);

    // ****************************************
    // order function
    // ****************************************
    function automatic burst_low_type order_low(input burst_low_type s, input burst_low_type c,
                                                input logic m);
        if (m == `BURST_INTERLEAVED)
        begin
            order_low = s ^ c;
        end
        else
        begin
            order_low = burst_low_type'(s + c);
        end
    endfunction

    burst_low_type seed_q;
    burst_low_type count_q;
    burst_low_type count_inc;

    // ****************************************
    // counter
    // ****************************************
    assign count_inc = burst_low_type'(count_q + 2'h1);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seed_q <= `BURST_LOW_RESET;
            count_q <= `BURST_LOW_RESET;
        end
        else if (load)
        begin
            seed_q <= seed;
            count_q <= `BURST_LOW_RESET;
        end
        else if (step)
        begin
            count_q <= count_inc;
        end
    end

    // mode strap picks the order directly
    assign cur_low = order_low(seed_q, count_q, mode);
    assign next_low = order_low(seed_q, count_inc, mode);

    // ****************************************
    // checks
    // ****************************************
    chk_burst_wrap: assert property (@(posedge clock) disable iff (!rst_n)
        (step && !load)[*4] |=> cur_low == $past(cur_low, 4))
        else $error("burst counter did not wrap after four steps");

    chk_linear_step: assert property (@(posedge clock) disable iff (!rst_n)
        (step && !load && mode == `BURST_LINEAR) |=>
        cur_low == burst_low_type'($past(cur_low) + 2'h1))
        else $error("linear burst step wrong");

    chk_seed_load: assert property (@(posedge clock) disable iff (!rst_n)
        load |=> cur_low == $past(seed))
        else $error("burst counter not seeded from address");

endmodule

//--- cache_ctrl_model.sv
// cache controller model driving the synchronous side of the sram port
// assumes the bench calls cyc once per clock and owns reset, sleep, strap and output enable
`timescale 1ns/10ps
module cache_ctrl_model
    import sram_port_pkg::*;
(
    input wire logic clock,
    input wire logic [31:0] data_out,
    input wire logic data_oe_n,
    output logic [16:0] addr,
    output logic pstb_n,
    output logic cstb_n,
    output logic advance_n,
    output logic all_wr_n,
    output logic qual_n,
    output logic [3:0] lanes_n,
    output logic sel_one_n,
    output logic sel_two,
    output logic sel_three_n,
    output logic [31:0] data_in
);
    logic drive_q;
    logic [31:0] wdata_q;
    logic [31:0] last_q;

    // ****************************************
    // data line level
    // ****************************************
    always_comb
    begin
        if (drive_q)
            data_in = wdata_q;
        else if (!data_oe_n)
            data_in = data_out;
        else
            data_in = ~last_q; // released line shows no stale value
    end

    always @(posedge clock)
        last_q <= data_in;

    initial
    begin
        {pstb_n, cstb_n, advance_n, all_wr_n, qual_n} = 5'h1F;
        lanes_n = 4'hF;
        {sel_one_n, sel_two, sel_three_n} = 3'h2;
        addr = 17'h00000;
        drive_q = 1'h0;
        wdata_q = 32'h00000000;
        last_q = 32'h00000000;
    end

    // ****************************************
    // one bus cycle, driven after the falling edge
    // ****************************************
    task automatic cyc(input logic [4:0] ctl, input logic [3:0] lanes, input logic [2:0] sel,
        input logic [16:0] a, input logic [31:0] d);
        @(negedge clock);
        {pstb_n, cstb_n, advance_n, all_wr_n} = ctl[4:1];
        qual_n = ctl[0];
        lanes_n = lanes;
        {sel_one_n, sel_two, sel_three_n} = sel;
        addr = a;
        wdata_q = d;
        drive_q = !ctl[1] || !ctl[0]; // data driven whenever write controls are low
    endtask
endmodule

//--- sram_burst_port.sv
// synchronous port and storage of a 32-bit pipelined burst sram
// assumes inputs synchronous to CLOCK and a tristate buffer outside using DATA_OE_N
`timescale 1ns/10ps
`include "sram_port_regs.svh"
module sram_burst_port
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int DATA_W = `SRAM_DATA_W,
    parameter int LANES = `SRAM_LANES
)
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic PROCESSOR_ADDR_STROBE_N,
    input wire logic CONTROLLER_ADDR_STROBE_N,
    input wire logic BURST_ADVANCE_N,
    input wire logic ALL_BYTES_WRITE_N,
    input wire logic BYTE_WRITE_QUALIFY_N,
    input wire logic [LANES-1:0] BYTE_LANE_SELECT_N,
    input wire logic SELECT_ONE_N,
    input wire logic SELECT_TWO,
    input wire logic SELECT_THREE_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic SLEEP_REQUEST,
    input wire logic BURST_ORDER,
    input wire logic [DATA_W-1:0] DATA_IN,
    output logic [DATA_W-1:0] DATA_OUT,
    output logic DATA_OE_N
);

    // ****************************************
    // storage
    // ****************************************
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    port_state_type state_q;
    logic [ADDR_W-3:0] addr_hi_q;
    logic [ADDR_W-1:0] rd_addr_q;
    logic rd_pend_q;
    logic drive_q;
    logic [DATA_W-1:0] data_out_q;

    logic awake;
    logic selected;
    logic proc_go;
    logic ctrl_go;
    logic strobe;
    logic start;
    logic desel;
    logic cont;
    logic advance;
    logic write_ctl;
    logic do_write;
    logic do_read;
    logic from_desel;
    logic [LANES-1:0] write_lanes;
    logic [ADDR_W-1:0] addr_used;
    logic [DATA_W-1:0] mem_rd;
    burst_low_type cur_low;
    burst_low_type next_low;

    // ****************************************
    // access decode
    // ****************************************
    // sleep blocks all new activity; contents stay
    assign awake = !SLEEP_REQUEST;
    assign selected = !SELECT_ONE_N && SELECT_TWO && !SELECT_THREE_N;
    assign proc_go = awake && !PROCESSOR_ADDR_STROBE_N && !SELECT_ONE_N;
    assign ctrl_go = awake && !CONTROLLER_ADDR_STROBE_N && !proc_go;
    assign strobe = proc_go || ctrl_go;
    assign start = strobe && selected;
    assign desel = strobe && !selected;
    assign cont = awake && !strobe && state_q != ST_DESEL;
    assign advance = cont && !BURST_ADVANCE_N;
    assign from_desel = state_q == ST_DESEL;

    // ****************************************
    // write decode
    // ****************************************
    always_comb
    begin
        if (!ALL_BYTES_WRITE_N)
        begin
            write_lanes = `ALL_LANES;
        end
        else if (!BYTE_WRITE_QUALIFY_N)
        begin
            write_lanes = ~BYTE_LANE_SELECT_N;
        end
        else
        begin
            write_lanes = `NO_LANES;
        end
    end

    assign write_ctl = !ALL_BYTES_WRITE_N || !BYTE_WRITE_QUALIFY_N;
    // processor strobe edge ignores write controls; controller edge uses them
    assign do_write = ((start && !proc_go) || cont) && write_ctl;
    assign do_read = (start && (proc_go || !write_ctl)) || (cont && !write_ctl);

    // ****************************************
    // burst address
    // ****************************************
    burst_counter u_burst
    (
        .clock(CLOCK),
        .rst_n(RST_N),
        .load(start),
        .seed(ADDR[1:0]),
        .step(advance),
        .mode(BURST_ORDER),
        .cur_low(cur_low),
        .next_low(next_low)
    );

    always_comb
    begin
        if (start)
        begin
            addr_used = ADDR;
        end
        else if (advance)
        begin
            addr_used = {addr_hi_q, next_low};
        end
        else
        begin
            addr_used = {addr_hi_q, cur_low};
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            addr_hi_q <= '0;
        end
        else if (start)
        begin
            addr_hi_q <= ADDR[ADDR_W-1:2];
        end
    end

    // ****************************************
    // access state
    // ****************************************
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_q <= ST_DESEL;
        end
        else if (!awake || desel)
        begin
            state_q <= ST_DESEL;
        end
        else if (start || cont)
        begin
            state_q <= do_write ? ST_WRITE : ST_READ;
        end
    end

    // ****************************************
    // memory write
    // ****************************************
    always_ff @(posedge CLOCK)
    begin
        for (int i = 0; i < LANES; i++)
        begin
            if (do_write && write_lanes[i])
            begin
                // data pins sampled on this edge
                mem[addr_used][i*`SRAM_LANE_W +: `SRAM_LANE_W] <=
                    DATA_IN[i*`SRAM_LANE_W +: `SRAM_LANE_W];
            end
        end
    end

    // ****************************************
    // read pipeline
    // ****************************************
    assign mem_rd = mem[rd_addr_q];

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= '0;
        end
        else
        begin
            rd_pend_q <= do_read;
            rd_addr_q <= addr_used;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            data_out_q <= `DATA_OUT_RESET;
        end
        else if (rd_pend_q)
        begin
            data_out_q <= mem_rd;
        end
    end

    // ****************************************
    // output drive
    // ****************************************
    always_ff @(posedge CLOCK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            drive_q <= 1'b0;
        end
        else if (!awake || desel || do_write)
        begin
            drive_q <= 1'b0;
        end
        else if (start && from_desel)
        begin
            drive_q <= 1'b0;
        end
        else
        begin
            drive_q <= rd_pend_q;
        end
    end

    assign DATA_OUT = data_out_q;
    // enable acts without the clock
    assign DATA_OE_N = OUTPUT_ENABLE_N || !drive_q;

    // ****************************************
    // checks
    // ****************************************
    chk_addr_capture: assert property (@(posedge CLOCK) disable iff (!RST_N)
        start |=> addr_hi_q == $past(ADDR[ADDR_W-1:2]))
        else $error("address not captured on start");

    chk_proc_ignored: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!from_desel && SELECT_ONE_N && CONTROLLER_ADDR_STROBE_N && awake)
        |=> state_q != ST_DESEL)
        else $error("processor strobe acted with select one high");

    chk_both_strobes: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (!PROCESSOR_ADDR_STROBE_N && !CONTROLLER_ADDR_STROBE_N && selected && awake)
        |-> (proc_go && !ctrl_go && !do_write))
        else $error("controller strobe not ignored");

    chk_proc_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (proc_go && selected ##1 cont && !ALL_BYTES_WRITE_N) |-> do_write)
        else $error("processor write missed on second edge");

    chk_read_latency: assert property (@(posedge CLOCK) disable iff (!RST_N)
        do_read |=> ##1 DATA_OUT == $past(mem_rd))
        else $error("read data not one clock after address");

    chk_first_masked: assert property (@(posedge CLOCK) disable iff (!RST_N)
        (start && from_desel) |=> DATA_OE_N)
        else $error("outputs driven in first cycle after deselect");

    chk_write_hiz: assert property (@(posedge CLOCK) disable iff (!RST_N)
        do_write |=> DATA_OE_N)
        else $error("outputs driven after write");

    chk_oe_high: assert property (@(posedge CLOCK) disable iff (!RST_N)
        OUTPUT_ENABLE_N |-> DATA_OE_N)
        else $error("outputs driven with enable high");

    chk_sleep_idle: assert property (@(posedge CLOCK) disable iff (!RST_N)
        SLEEP_REQUEST |=> (state_q == ST_DESEL && DATA_OE_N))
        else $error("port active in sleep");

    chk_global_lanes: assert property (@(posedge CLOCK) disable iff (!RST_N)
        !ALL_BYTES_WRITE_N |-> write_lanes == `ALL_LANES)
        else $error("global write missed lanes");

    cov_read_drive: cover property (@(posedge CLOCK) disable iff (!RST_N)
        do_read ##1 1'b1 ##1 !DATA_OE_N);

    cov_ctrl_write: cover property (@(posedge CLOCK) disable iff (!RST_N)
        ctrl_go && start && do_write);

    cov_burst_four: cover property (@(posedge CLOCK) disable iff (!RST_N)
        start ##1 advance[*3]);

    cov_both_strobes: cover property (@(posedge CLOCK) disable iff (!RST_N)
        !PROCESSOR_ADDR_STROBE_N && !CONTROLLER_ADDR_STROBE_N && start);

endmodule

//--- sram_burst_port_tb.sv
// self-checking bench of the pipelined burst sram port
// assumes the controller model drives the bus and the strap moves only in reset
`timescale 1ns/10ps
module sram_burst_port_tb
    import sram_port_pkg::*;
;
    typedef struct packed {
        logic [4:0] ctl;
        logic [3:0] lanes;
        logic [2:0] sel;
        logic [16:0] a;
        logic [31:0] d;
        logic [31:0] eo;
        logic eoe;
    } row_type;

    logic clock = 1'h0;
    logic rst_n = 1'h0;
    logic oe_n = 1'h0;
    logic sleep = 1'h0;
    logic mode = 1'h1;
    logic [16:0] addr;
    logic pstb_n, cstb_n, advance_n, all_wr_n, qual_n, s1_n, s2, s3_n;
    logic [3:0] lanes_n;
    logic [31:0] din, dout;
    logic oe_pin_n;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    row_type rows [18] = '{
        '{5'h15, 4'hF, 3'h2, 17'h00012, 32'h000000A0, 32'h00000000, 1'h1},
        '{5'h19, 4'hF, 3'h2, 17'h00000, 32'h000000A1, 32'h00000000, 1'h1},
        '{5'h19, 4'hF, 3'h2, 17'h00000, 32'h000000A2, 32'h00000000, 1'h1},
        '{5'h19, 4'hF, 3'h2, 17'h00000, 32'h000000A3, 32'h00000000, 1'h1},
        '{5'h1E, 4'h7, 3'h2, 17'h00000, 32'h5A000000, 32'h00000000, 1'h1},
        '{5'h1B, 4'hF, 3'h2, 17'h00000, 32'h00000000, 32'h00000000, 1'h1},
        '{5'h1B, 4'hF, 3'h2, 17'h00000, 32'h00000000, 32'h000000A0, 1'h0},
        '{5'h1F, 4'hF, 3'h2, 17'h00000, 32'h00000000, 32'h000000A1, 1'h0},
        '{5'h0D, 4'hF, 3'h2, 17'h00010, 32'hFFFFFFFF, 32'h000000A1, 1'h0},
        '{5'h1D, 4'hF, 3'h2, 17'h00000, 32'h000000B0, 32'h000000A2, 1'h1},
        '{5'h17, 4'hF, 3'h0, 17'h00000, 32'h00000000, 32'h000000A2, 1'h1},
        '{5'h0F, 4'hF, 3'h2, 17'h00011, 32'h00000000, 32'h000000A2, 1'h1},
        '{5'h1F, 4'hF, 3'h2, 17'h00000, 32'h00000000, 32'h5A0000A3, 1'h0},
        '{5'h17, 4'hF, 3'h2, 17'h00010, 32'h00000000, 32'h5A0000A3, 1'h0},
        '{5'h05, 4'hF, 3'h2, 17'h00013, 32'h000000C0, 32'h000000B0, 1'h0},
        '{5'h0F, 4'hF, 3'h6, 17'h00012, 32'h00000000, 32'h000000A1, 1'h0},
        '{5'h1F, 4'hF, 3'h2, 17'h00000, 32'h00000000, 32'h000000A1, 1'h0},
        '{5'h17, 4'hF, 3'h3, 17'h00000, 32'h00000000, 32'h000000A1, 1'h1}
    };

    always #5 clock = ~clock;

    cache_ctrl_model ctrl (.clock(clock), .data_out(dout), .data_oe_n(oe_pin_n), .addr(addr),
        .pstb_n(pstb_n), .cstb_n(cstb_n), .advance_n(advance_n), .all_wr_n(all_wr_n),
        .qual_n(qual_n), .lanes_n(lanes_n), .sel_one_n(s1_n), .sel_two(s2),
        .sel_three_n(s3_n), .data_in(din));

    sram_burst_port dut (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr),
        .PROCESSOR_ADDR_STROBE_N(pstb_n), .CONTROLLER_ADDR_STROBE_N(cstb_n),
        .BURST_ADVANCE_N(advance_n), .ALL_BYTES_WRITE_N(all_wr_n),
        .BYTE_WRITE_QUALIFY_N(qual_n), .BYTE_LANE_SELECT_N(lanes_n), .SELECT_ONE_N(s1_n),
        .SELECT_TWO(s2),
        .SELECT_THREE_N(s3_n), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(sleep),
        .BURST_ORDER(mode), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_N(oe_pin_n));

    // ****************************************
    // compare and report
    // ****************************************
    task automatic chk_data(input logic [31:0] exp);
        n_tests++;
        if (dout !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: data %h, expected %h", $time, dout, exp);
        end
    endtask

    task automatic chk_oe(input logic exp);
        n_tests++;
        if (oe_pin_n !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: drive enable %b, expected %b", $time, oe_pin_n, exp);
        end
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic step(input row_type r);
        ctrl.cyc(r.ctl, r.lanes, r.sel, r.a, r.d);
        @(posedge clock);
        #1;
        chk_data(r.eo);
        chk_oe(r.eoe);
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 500)
        begin
            err_total++;
            results();
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (2) @(negedge clock);
        rst_n = 1'h1;
        foreach (rows[i])
            step(rows[i]);
        // reset mid-run, strap moved to linear only while held
        @(negedge clock);
        rst_n = 1'h0;
        mode = 1'h0;
        #1;
        chk_data(32'h00000000);
        chk_oe(1'h1);
        @(negedge clock);
        rst_n = 1'h1;
        // linear burst from 11 over the kept contents
        step('{5'h0F, 4'hF, 3'h2, 17'h00011, 32'h0, 32'h00000000, 1'h1});
        step('{5'h1B, 4'hF, 3'h2, 17'h00000, 32'h0, 32'h5A0000A3, 1'h0});
        step('{5'h1B, 4'hF, 3'h2, 17'h00000, 32'h0, 32'h000000A0, 1'h0});
        step('{5'h1B, 4'hF, 3'h2, 17'h00000, 32'h0, 32'h000000A1, 1'h0});
        step('{5'h1B, 4'hF, 3'h2, 17'h00000, 32'h0, 32'h000000B0, 1'h0});
        step('{5'h1F, 4'hF, 3'h2, 17'h00000, 32'h0, 32'h5A0000A3, 1'h0});
        // sleep drops drive and keeps contents
        @(negedge clock);
        sleep = 1'h1;
        step('{5'h1F, 4'hF, 3'h2, 17'h00000, 32'h0, 32'h5A0000A3, 1'h1});
        @(negedge clock);
        sleep = 1'h0;
        step('{5'h0F, 4'hF, 3'h2, 17'h00010, 32'h0, 32'h5A0000A3, 1'h1});
        step('{5'h1F, 4'hF, 3'h2, 17'h00000, 32'h0, 32'h000000B0, 1'h0});
        // output enable acts without a clock
        @(negedge clock);
        oe_n = 1'h1;
        #1;
        chk_oe(1'h1);
        @(negedge clock);
        oe_n = 1'h0;
        #1;
        chk_oe(1'h0);
        results();
    end
endmodule

//--- sram_port_pkg.sv
// types shared by the sram port modules
// assumes sram_port_regs.svh is on the include path
package sram_port_pkg;

`include "sram_port_regs.svh"

    // access state of the port
    typedef enum logic [2:0]
    {
        ST_DESEL = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } port_state_type;

    typedef logic [`BURST_CNT_W-1:0] burst_low_type;

endpackage

//--- sram_port_regs.svh
// constants of the pipelined burst sram port
// assumes inclusion by bare name from the package and the design modules
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

`define SRAM_ADDR_W 17
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define BURST_CNT_W 2
`define BURST_LINEAR 1'b0
`define BURST_INTERLEAVED 1'b1
`define ALL_LANES 4'hF
`define NO_LANES 4'h0
`define BURST_LOW_RESET 2'h0
`define DATA_OUT_RESET 32'h0000_0000

`endif
